// ---- pewc_pkg.sv ----
package pewc_pkg;

  localparam int unsigned PEWC_DATA_W = 8;
  localparam int unsigned PEWC_CHAN_N = 9;
  localparam int unsigned PEWC_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] PEWC_CTRL_OFF = 8'h00;
  localparam logic [7:0] PEWC_HALF_OFF = 8'h04;
  localparam logic [7:0] PEWC_STAT_OFF = 8'h08;
  localparam logic [7:0] PEWC_CHAR_OFF = 8'h0c;

  // control register fields
  localparam int unsigned PEWC_CTRL_HOSTPAR_BIT = 0;
  localparam int unsigned PEWC_CTRL_ENABLE_BIT = 1;
  localparam logic [1:0] PEWC_CTRL_RESET = 2'h0;

  // half-cell length in clk_sys cycles
  localparam int unsigned PEWC_HALF_W = 16;
  localparam logic [15:0] PEWC_HALF_RESET = 16'h0014;
  localparam logic [15:0] PEWC_HALF_MIN = 16'h0002;

  // channel reset groups: bit i is data channel i
  localparam logic [7:0] PEWC_GROUP_A_MASK = 8'he5;
  localparam logic [7:0] PEWC_GROUP_B_MASK = 8'h1a;

  // sequencing levels from the write control logic
  typedef struct packed {
    logic data_phase_window;
    logic postamble_one_window;
    logic force_ones_n;
    logic toggle_control_n;
    logic recording_window;
    logic group_a_reset_n;
    logic group_b_reset_n;
    logic file_mark_command;
  } pewc_seq_t;

  // character from the host controller
  typedef struct packed {
    logic host_parity_line;
    logic [7:0] host_data_lines;
  } pewc_host_t;

  // encoded channels towards the transport
  typedef struct packed {
    logic encoded_parity_out;
    logic [7:0] encoded_data_out;
  } pewc_enc_t;

endpackage

// ---- pewc_write_channels.sv ----
`timescale 1ns/100ps
// Contract
// - odd parity is generated over the eight write data bits
// - a static control bit picks generated parity or the host parity bit
// - nine channel encoders add pattern bits and phase-encode their streams
// - host data reaches encoders only in the data phase, else zeros
// - each encoding flip-flop is clocked every half cell while encoding
// - at each cell boundary each flip-flop loads its bit to record
// - at mid cell each flip-flop inverts; load and invert then alternate
// - in the loading half, set gets the bit and reset its complement
// - force-ones low in the loading half captures a one at the boundary
// - in the first half, force-ones and toggle drive both inputs high
// - idle flip-flops are clamped by recording window and group resets
// - file mark keeps channels 1, 3, 4 reset; others encode zeros
// - identification: both groups reset, only parity channel encodes
// - encoded channels drive transport lines with a write strobe
// - group A is channels 0,2,5,6,7; group B is 1,3,4 plus file mark
module pewc_write_channels #(
  parameter int unsigned HALF_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pewc_pkg::pewc_host_t host_in,
  input wire pewc_pkg::pewc_seq_t seq_in,
  output pewc_pkg::pewc_enc_t enc_out,
  output logic transport_write_strobe,
  output logic char_transfer_strobe,
  output logic cell_load_half
);
  import pewc_pkg::*;

  // apb slave, one wait state on every access
  logic [1:0] ctrl_reg;
  logic [HALF_W-1:0] half_reg;
  logic [HALF_W-1:0] half_next;
  logic acc_done;

  assign acc_done = psel && penable && pready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      PEWC_CTRL_OFF, PEWC_HALF_OFF, PEWC_STAT_OFF, PEWC_CHAR_OFF: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // half-cell length below two cycles would collide load and mid-cell strobe
  always_comb begin
    half_next = pwdata[HALF_W-1:0];
    if (half_next < PEWC_HALF_MIN[HALF_W-1:0]) begin
      half_next = PEWC_HALF_MIN[HALF_W-1:0];
    end
  end

  // each register has its own write port
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= PEWC_CTRL_RESET;
    end else if (acc_done && pwrite && (paddr == PEWC_CTRL_OFF)) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      half_reg <= PEWC_HALF_RESET[HALF_W-1:0];
    end else if (acc_done && pwrite && (paddr == PEWC_HALF_OFF)) begin
      half_reg <= half_next;
    end
  end

  // host pins: three stages per bit, a bit moves once stages two and three agree
  logic [8:0] host_stable;

  genvar g;
  generate
    for (g = 0; g < PEWC_CHAN_N; g++) begin : g_host
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic stable_reg;
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= host_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      // the agreement test filters a glitch that stage one caught half-way
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stable_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
          stable_reg <= s3_reg;
        end
      end
      assign host_stable[g] = stable_reg;
    end
  endgenerate

  // sequencing levels come from logic on the same clock, no synchroniser
  pewc_seq_t sq;
  assign sq = seq_in;

  // half-cell divider
  logic enc_on;
  logic [HALF_W-1:0] div_cnt;
  logic half_tick;
  logic mid_half;
  logic boundary;

  assign enc_on = ctrl_reg[PEWC_CTRL_ENABLE_BIT];
  always_comb begin
    half_tick = 1'b0;
    mid_half = 1'b0;
    if (enc_on) begin
      half_tick = (div_cnt == half_reg - 1'b1);
      mid_half = (div_cnt == (half_reg >> 1) - 1'b1);
    end
  end
  assign boundary = half_tick && cell_load_half;

  always_ff @(posedge clk_sys) begin
    if (rst || !enc_on) begin
      div_cnt <= '0;
    end else if (half_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // which half of the cell the encoders are in
  typedef enum logic {PH_FIRST, PH_LOAD} pewc_phase_t;
  pewc_phase_t phase_reg;
  pewc_phase_t phase_next;

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_FIRST: phase_next = PH_LOAD;
      PH_LOAD: phase_next = PH_FIRST;
      default: phase_next = PH_FIRST;
    endcase
  end

  // high during the loading (second) half that ends at a cell boundary
  always_ff @(posedge clk_sys) begin
    if (rst || !enc_on) begin
      phase_reg <= PH_FIRST;
      cell_load_half <= 1'b0;
    end else if (half_tick) begin
      phase_reg <= phase_next;
      cell_load_half <= (phase_next == PH_LOAD);
    end
  end

  // character staging
  logic [7:0] write_data_bits;
  logic host_parity_line;
  logic generated_odd_parity;
  logic par_sel;
  logic [8:0] staged_reg;

  assign write_data_bits = host_stable[7:0];
  assign host_parity_line = host_stable[8];
  // parity chain, one xor stage per data bit, seeded with one for odd parity
  logic [8:0] par_chain;
  assign par_chain[0] = 1'b1;
  generate
    for (g = 0; g < PEWC_DATA_W; g++) begin : g_par
      assign par_chain[g + 1] = par_chain[g] ^ write_data_bits[g];
    end
  endgenerate
  assign generated_odd_parity = par_chain[PEWC_DATA_W];
  assign par_sel = ctrl_reg[PEWC_CTRL_HOSTPAR_BIT] ? host_parity_line
                                                   : generated_odd_parity;

  // only the data phase lets host bits through, other phases record zeros
  logic [8:0] gated_bits;
  generate
    for (g = 0; g < PEWC_CHAN_N; g++) begin : g_gate
      if (g < PEWC_DATA_W) begin : g_dbit
        assign gated_bits[g] = write_data_bits[g] && sq.data_phase_window;
      end else begin : g_pbit
        assign gated_bits[g] = par_sel && sq.data_phase_window;
      end
    end
  endgenerate

  // the character taken at a boundary is loaded at the following boundary and recorded during the cell after next,
  // so the host gets a full cell after the strobe to present the next one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      staged_reg <= 9'h000;
    end else if (boundary) begin
      staged_reg <= gated_bits;
    end
  end

  // channel clamps
  logic clamp_a;
  logic clamp_b;
  logic clamp_p;
  logic [8:0] clamp;

  assign clamp_p = !sq.recording_window;
  assign clamp_a = clamp_p || !sq.group_a_reset_n;
  assign clamp_b = clamp_a || !sq.group_b_reset_n || sq.file_mark_command;

  // parity has only the window clamp, group A channels follow group A, group B channels also take the group A clamp
  function automatic logic clamp_of(input int unsigned ch, input logic ca, input logic cb,
                                    input logic cp);
    if (ch >= PEWC_DATA_W) begin
      clamp_of = cp;
    end else if (PEWC_GROUP_A_MASK[ch[2:0]]) begin
      clamp_of = ca;
    end else begin
      clamp_of = cb;
    end
  endfunction

  generate
    for (g = 0; g < PEWC_CHAN_N; g++) begin : g_clamp
      assign clamp[g] = clamp_of(g, clamp_a, clamp_b, clamp_p);
    end
  endgenerate

  // jk pair per channel: forced ones beat the data bit, toggle beats both
  function automatic logic [1:0] jk_of(input logic bit_in, input logic ones_in,
                                       input logic tog_in);
    logic j_v;
    logic k_v;
    j_v = bit_in || ones_in || tog_in;
    k_v = (!bit_in && !ones_in) || tog_in;
    jk_of = {j_v, k_v};
  endfunction

  // nine jk encoders
  logic ones;
  logic tog;
  logic [8:0] enc_reg;

  assign ones = !sq.force_ones_n;
  assign tog = !sq.toggle_control_n;

  generate
    for (g = 0; g < 9; g++) begin : g_enc
      logic [1:0] jk;
      assign jk = jk_of(staged_reg[g], ones, tog);
      always_ff @(posedge clk_sys) begin
        if (rst || clamp[g]) begin
          enc_reg[g] <= 1'b0;
        end else if (half_tick) begin
          case (jk)
            2'b11: begin
              enc_reg[g] <= !enc_reg[g];
            end
            2'b10: begin
              enc_reg[g] <= 1'b1;
            end
            2'b01: begin
              enc_reg[g] <= 1'b0;
            end
            default: begin
              enc_reg[g] <= enc_reg[g];
            end
          endcase
        end
      end
    end
  endgenerate

  assign enc_out = enc_reg;

  // centre of each half cell, output lines have settled by then
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      transport_write_strobe <= 1'b0;
    end else begin
      transport_write_strobe <= mid_half && sq.recording_window;
    end
  end

  // one cycle after the boundary, once the character has been staged
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      char_transfer_strobe <= 1'b0;
    end else begin
      char_transfer_strobe <= boundary && sq.data_phase_window;
    end
  end

  // read data: unmapped offsets read zero and raise the error with pready
  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    case (a)
      PEWC_CTRL_OFF: read_word = {30'h0, ctrl_reg};
      PEWC_HALF_OFF: read_word = {{(32 - HALF_W){1'b0}}, half_reg};
      PEWC_STAT_OFF: read_word = {22'h0, cell_load_half, enc_reg};
      PEWC_CHAR_OFF: read_word = {23'h0, staged_reg};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      prdata <= read_word(paddr);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !addr_known(paddr);
    end
  end

endmodule

// ---- pewc_chk.sv ----
`timescale 1ns/100ps
module pewc_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pewc_pkg::pewc_seq_t seq_in,
  input wire pewc_pkg::pewc_enc_t enc_out,
  input wire logic transport_write_strobe,
  input wire logic char_transfer_strobe,
  input wire logic cell_load_half
);
  import pewc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_rdy_a: assert property (pslverr |-> pready && prdata == 0) else $error("bad error");
  rst_zero_a: assert property ($fell(rst) |-> enc_out == 0 && !pready) else $error("no reset");
  par_clamp_a: assert property (
    (!seq_in.recording_window)[*2] |-> !enc_out.encoded_parity_out) else $error("par clamp");
  fm_clamp_a: assert property (
    seq_in.file_mark_command[*2] |-> (enc_out.encoded_data_out & 8'h1a) == 0)
    else $error("file mark clamp");
  gb_clamp_a: assert property (
    (!seq_in.group_b_reset_n)[*2] |-> (enc_out.encoded_data_out & 8'h1a) == 0)
    else $error("group b clamp");
  ga_clamp_a: assert property (
    (!seq_in.group_a_reset_n)[*2] |-> (enc_out.encoded_data_out & 8'he5) == 0)
    else $error("group a clamp");
  ws_pulse_a: assert property (
    transport_write_strobe |=> !transport_write_strobe) else $error("strobe held");
  cs_bound_a: assert property (
    char_transfer_strobe |-> $fell(cell_load_half)) else $error("char strobe late");
endmodule
bind pewc_write_channels pewc_chk u_chk (.clk_sys, .rst, .prdata, .pready, .pslverr,
  .seq_in, .enc_out, .transport_write_strobe, .char_transfer_strobe, .cell_load_half);

// ---- pewc_xport.sv ----
`timescale 1ns/100ps
module pewc_xport (
  input wire logic clk_sys,
  input wire logic transport_write_strobe,
  input wire logic char_transfer_strobe,
  input wire pewc_pkg::pewc_enc_t enc_out,
  input wire logic [8:0] next_char,
  output pewc_pkg::pewc_host_t host_in,
  output pewc_pkg::pewc_enc_t write_reg
);
  import pewc_pkg::*;
  initial host_in = '0;
  initial write_reg = '0;
  // lines are only trusted on the strobe edge
  always @(posedge clk_sys) begin
    if (transport_write_strobe)
      write_reg <= enc_out;
    if (char_transfer_strobe)
      host_in <= next_char;
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value at %0t: %h not %h", $time, g, e); \
  end \
end
module tb;
  import pewc_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, frc = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic transport_write_strobe, char_transfer_strobe, cell_load_half;
  logic [8:0] next_char = '0;
  pewc_host_t host_in;
  pewc_seq_t seq = 8'h36;
  pewc_enc_t enc_out, write_reg;
  int fail_count = 0, samples_checked = 0;
  always #25 clk_sys = ~clk_sys;
  pewc_write_channels #(.HALF_W(16)) DUT (.clk_sys, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .host_in, .seq_in(seq), .enc_out,
    .transport_write_strobe, .char_transfer_strobe, .cell_load_half);
  pewc_xport u_xp (.clk_sys, .transport_write_strobe, .char_transfer_strobe,
    .enc_out, .next_char, .host_in, .write_reg);
  // toggle low in the first half, forced ones only in the loading half
  always @(posedge clk_sys) begin
    seq.toggle_control_n <= cell_load_half;
    seq.force_ones_n <= !(cell_load_half && frc);
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clk_sys);
    if (++n > 99) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do tick(n); while (pready !== 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic mode(input logic [4:0] s, input logic f);
    @(posedge clk_sys);
    {seq.data_phase_window, seq.recording_window, seq.group_a_reset_n,
      seq.group_b_reset_n, seq.file_mark_command} <= s;
    frc <= f;
  endtask
  task automatic half(input logic v, input int k);
    int n = 0;
    repeat (k) begin
      while (cell_load_half !== !v) tick(n);
      while (cell_load_half !== v) tick(n);
    end
  endtask
  task automatic s_regs();
    apb(0, 8'h00, 0);
    `CHK(rd, 32'h0)
    apb(0, 8'h04, 0);
    `CHK(rd, {16'h0, PEWC_HALF_RESET})
    apb(0, 8'h10, 0);
    `CHK(er, 1'b1)
    apb(1, 8'h04, 4);
    apb(0, 8'h04, 0);
    `CHK(rd, 32'h4)
    apb(1, 8'h00, 2);
  endtask
  task automatic s_idle();
    mode(5'b00110, 0);
    half(1, 2);
    `CHK(enc_out, 9'h0)
  endtask
  task automatic s_zero(input logic f);
    mode(5'b01110, f);
    half(0, 2);
    `CHK(enc_out, {9{f}})
    half(1, 1);
    `CHK(enc_out, {9{!f}})
  endtask
  task automatic s_data();
    int n = 0;
    next_char <= 9'h05a;
    mode(5'b11110, 0);
    half(0, 4);
    `CHK(enc_out, 9'h15a)
    half(1, 1);
    `CHK(enc_out, 9'h0a5)
    while (transport_write_strobe !== 1) tick(n);
    @(posedge clk_sys);
    `CHK(write_reg, 9'h0a5)
    apb(1, 8'h00, 3);
    half(0, 3);
    `CHK(enc_out, 9'h05a)
    apb(1, 8'h00, 2);
  endtask
  task automatic s_marks();
    mode(5'b01111, 0);
    half(1, 2);
    `CHK(enc_out, 9'h1e5)
    mode(5'b01000, 0);
    half(1, 2);
    `CHK(enc_out, 9'h100)
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    s_regs();
    s_idle();
    s_zero(0);
    s_zero(1);
    s_data();
    s_marks();
    print_verdict();
  end
endmodule
